// File: include/gei_pkg.sv
// Constants, code maps and helpers shared by the gateway error indicator
package gei_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int     CLK_HZ            = 10_000_000;
	localparam int     WARN_HOLD_S       = 60;
	localparam longint WARN_HOLD_CYC     = longint'(WARN_HOLD_S) * longint'(CLK_HZ);
	localparam int     HOLD_W            = 30;
	localparam int     MS_PER_S          = 1000;
	localparam int     CYC_PER_MS        = CLK_HZ / MS_PER_S;
	localparam int     PRE_W             = 14;
	localparam int     EXPL_TIMEOUT_MULT = 4;

	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_EPR     = 8'h04;
	localparam logic [7:0]  ADDR_STATUS  = 8'h08;
	localparam logic [7:0]  ADDR_DETAIL  = 8'h0c;
	localparam int          CTRL_SCRIPTED_BIT = 0;
	localparam int          CTRL_CONFIG_BIT   = 1;
	localparam int          CTRL_PATTERN_LSB  = 4;
	localparam logic [15:0] EPR_RST      = 16'h0000;
	localparam logic [3:0]  PATTERN_RST  = 4'h0;

	// ----------------------------------------------------------------
	// Error numbers
	// ----------------------------------------------------------------
	localparam logic [3:0] CODE_NONE        = 4'h0;
	localparam logic [3:0] CODE_SERIOUS_MAX = 4'h5;
	localparam logic [3:0] CODE_RESERVED6   = 4'h6;
	localparam logic [3:0] CODE_FB_GENERAL  = 4'ha;
	localparam logic [3:0] SC_RESERVED12    = 4'hc;
	localparam logic [3:0] SC_RESERVED13    = 4'hd;
	localparam logic [3:0] SC_RESERVED15    = 4'hf;

	// ----------------------------------------------------------------
	// One-hot detail fault word
	// ----------------------------------------------------------------
	localparam int DETAIL_W           = 11;
	localparam int DET_DUP_NODE       = 0;
	localparam int DET_RX_QUEUE       = 1;
	localparam int DET_TX_QUEUE       = 2;
	localparam int DET_IO_SEND        = 3;
	localparam int DET_BUS_OFF        = 4;
	localparam int DET_CTRL_OVERRUN   = 5;
	localparam int DET_EXPL_TIMEOUT   = 6;
	localparam int DET_IO_TIMEOUT     = 7;
	localparam int DET_IO_DELETED     = 8;
	localparam int DET_NET_RESET      = 9;
	localparam int DET_BUS_SENSE      = 10;

	// Reserved numbers differ between the two product variants
	function automatic logic code_legal(input logic scripted, input logic [3:0] code);
		if (code == CODE_NONE || code == CODE_RESERVED6) begin
			return 1'b0;
		end
		if (scripted && (code == SC_RESERVED12 || code == SC_RESERVED13 ||
			code == SC_RESERVED15)) begin
			return 1'b0;
		end
		return 1'b1;
	endfunction

endpackage

// File: hdl/gei_countdown.sv
// Loadable down-counter that marks a hold interval and its expiry
`timescale 1ns/10ps
`default_nettype none
module gei_countdown #(
	parameter int W = 30
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Control
	input  wire logic         load_in,
	input  wire logic [W-1:0] load_value_in,
	// Status
	output logic              active_out,
	output logic              expire_out
);

	logic [W-1:0] count;

	// A reload in the last cycle restarts the interval instead of ending it
	assign expire_out = active_out && (count == '0) && !load_in;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			count      <= '0;
			active_out <= 1'b0;
		end else if (load_in) begin
			count      <= load_value_in;
			active_out <= 1'b1;
		end else if (active_out) begin
			if (count == '0) begin
				active_out <= 1'b0;
			end else begin
				count <= count - W'(1);
			end
		end
	end

	a_hold_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		expire_out |=> !active_out)
		else $error("hold interval did not end on expiry");

endmodule
`default_nettype wire

// File: hdl/gei_expl_watchdog.sv
// Explicit connection watchdog: no traffic for four packet intervals
`timescale 1ns/10ps
`default_nettype none
module gei_expl_watchdog import gei_pkg::*; #(
	parameter int EPR_W = 16
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Expected packet interval in ms, zero disables
	input  wire logic [EPR_W-1:0] epr_ms_in,
	input  wire logic             traffic_in,
	// One-cycle timeout event
	output logic                  timeout_out
);

	localparam int         MS_W  = EPR_W + 2;
	localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(CYC_PER_MS - 1);

	logic [PRE_W-1:0] pre;
	logic [MS_W-1:0]  ms_count;
	logic [MS_W-1:0]  limit;
	logic             armed;
	logic             ms_tick;
	logic             hit;

	assign ms_tick = (pre == '0);
	assign limit   = MS_W'(epr_ms_in) * MS_W'(EXPL_TIMEOUT_MULT);
	assign hit     = armed && (limit != '0) && (ms_count >= limit);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in || traffic_in || ms_tick) begin
			pre <= PRE_LOAD;
		end else begin
			pre <= pre - PRE_W'(1);
		end
	end

	// Count stops at the limit so one silence gives one event
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || traffic_in) begin
			ms_count <= '0;
		end else if (ms_tick && armed && ms_count < limit) begin
			ms_count <= ms_count + MS_W'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			armed       <= 1'b1;
			timeout_out <= 1'b0;
		end else begin
			timeout_out <= hit && !traffic_in;
			if (traffic_in) begin
				armed <= 1'b1;
			end else if (hit) begin
				armed <= 1'b0;
			end
		end
	end

	a_expl_timeout: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		timeout_out |-> !armed && ms_count == limit && limit != '0)
		else $error("explicit timeout raised before four intervals");

endmodule
`default_nettype wire

// File: hdl/gei_error_indicator.sv
// Gateway error indicator: error latch, warning hold, display, emergency, APB
`timescale 1ns/10ps
`default_nettype none
module gei_error_indicator import gei_pkg::*; #(
	parameter longint WARN_HOLD_CYCLES = WARN_HOLD_CYC,
	parameter int     EPR_W            = 16
) (
	// Clock and reset
	input  wire logic                CLK_SYS_IN,
	input  wire logic                RESET_N_IN,
	// APB slave
	input  wire logic                PSEL_IN,
	input  wire logic                PENABLE_IN,
	input  wire logic                PWRITE_IN,
	input  wire logic [7:0]          PADDR_IN,
	input  wire logic [31:0]         PWDATA_IN,
	output logic      [31:0]         PRDATA_OUT,
	output logic                     PREADY_OUT,
	output logic                     PSLVERR_OUT,
	// Error sources from the gateway logic
	input  wire logic                ERR_RAISE_IN,
	input  wire logic [3:0]          ERR_CODE_IN,
	input  wire logic [DETAIL_W-1:0] DETAIL_FAULT_IN,
	input  wire logic                EXPL_TRAFFIC_IN,
	// Indicators
	output logic                     STATE_RED_OUT,
	output logic      [3:0]          ERR_NUM_OUT,
	// Emergency message to the fieldbus side
	output logic                     EMCY_VALID_OUT,
	output logic      [3:0]          EMCY_CODE_OUT,
	input  wire logic                EMCY_READY_IN
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(WARN_HOLD_CYCLES - 1);

	logic                ctrl_scripted;
	logic                ctrl_config;
	logic [3:0]          ctrl_pattern;
	logic [EPR_W-1:0]    epr_ms;
	logic [DETAIL_W-1:0] detail_fault_word;
	logic [DETAIL_W-1:0] detail_set;
	logic [DETAIL_W-1:0] detail_clr;
	logic [DETAIL_W-1:0] next_detail;
	logic                serious_latched;
	logic [3:0]          serious_code;
	logic [3:0]          warn_code;
	logic                warn_active;
	logic                warn_load;
	logic                raise_ok;
	logic                raise_serious;
	logic                raise_warn;
	logic                fb_active;
	logic                fb_active_q;
	logic                fb_rise;
	logic                emcy_event;
	logic [3:0]          emcy_new_code;
	logic                err_any;
	logic [3:0]          next_disp;
	logic                expl_timeout;
	logic                apb_setup;
	logic                apb_write;
	logic                addr_hit;
	logic [31:0]         next_rdata;

	// ----------------------------------------------------------------
	// Error classification
	// ----------------------------------------------------------------
	// Reserved numbers of the active variant are dropped at the source
	assign raise_ok      = ERR_RAISE_IN && code_legal(ctrl_scripted, ERR_CODE_IN);
	assign raise_serious = raise_ok && (ERR_CODE_IN <= CODE_SERIOUS_MAX);
	assign raise_warn    = raise_ok && !raise_serious;
	assign fb_active     = ctrl_scripted && (detail_fault_word != '0);
	assign fb_rise       = fb_active && !fb_active_q;
	// A live fieldbus fault keeps reloading the hold so 10 stays up
	assign warn_load     = raise_warn || fb_active;

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			fb_active_q <= 1'b0;
		end else begin
			fb_active_q <= fb_active;
		end
	end

	// ----------------------------------------------------------------
	// Serious error latch
	// ----------------------------------------------------------------
	// Only reset clears it; the first serious number is the one kept
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			serious_latched <= 1'b0;
			serious_code    <= CODE_NONE;
		end else if (raise_serious && !serious_latched) begin
			serious_latched <= 1'b1;
			serious_code    <= ERR_CODE_IN;
		end
	end

	// ----------------------------------------------------------------
	// Warning hold
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			warn_code <= CODE_NONE;
		end else if (fb_active) begin
			warn_code <= CODE_FB_GENERAL;
		end else if (raise_warn) begin
			warn_code <= ERR_CODE_IN;
		end
	end

	gei_countdown #(
		.W (HOLD_W)
	) u_warn_hold (
		.clk_in        (CLK_SYS_IN),
		.rst_n_in      (RESET_N_IN),
		.load_in       (warn_load),
		.load_value_in (HOLD_LOAD),
		.active_out    (warn_active),
		.expire_out    ()
	);

	// ----------------------------------------------------------------
	// Display
	// ----------------------------------------------------------------
	assign err_any = serious_latched || warn_active;

	always_comb begin
		if (serious_latched) begin
			next_disp = serious_code;
		end else if (warn_active) begin
			next_disp = warn_code;
		end else begin
			next_disp = CODE_NONE;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			STATE_RED_OUT <= 1'b0;
			ERR_NUM_OUT   <= CODE_NONE;
		end else begin
			STATE_RED_OUT <= err_any;
			// Config mode hands ERR_NUM_OUT over to ctrl_pattern; STATE_RED_OUT still follows the error state
			ERR_NUM_OUT   <= ctrl_config ? ctrl_pattern : next_disp;
		end
	end

	// ----------------------------------------------------------------
	// Emergency message
	// ----------------------------------------------------------------
	assign emcy_event    = raise_ok || fb_rise;
	assign emcy_new_code = raise_ok ? ERR_CODE_IN : CODE_FB_GENERAL;

	// One slot: a newer event overwrites one not yet taken, set wins
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			EMCY_VALID_OUT <= 1'b0;
			EMCY_CODE_OUT  <= CODE_NONE;
		end else if (emcy_event) begin
			EMCY_VALID_OUT <= 1'b1;
			EMCY_CODE_OUT  <= emcy_new_code;
		end else if (EMCY_READY_IN) begin
			EMCY_VALID_OUT <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Detail fault word
	// ----------------------------------------------------------------
	gei_expl_watchdog #(
		.EPR_W (EPR_W)
	) u_expl_wd (
		.clk_in      (CLK_SYS_IN),
		.rst_n_in    (RESET_N_IN),
		.epr_ms_in   (epr_ms),
		.traffic_in  (EXPL_TRAFFIC_IN),
		.timeout_out (expl_timeout)
	);

	always_comb begin
		detail_set                   = DETAIL_FAULT_IN;
		detail_set[DET_EXPL_TIMEOUT] = expl_timeout;
		detail_clr                   = '0;
		if (apb_write && PADDR_IN == ADDR_DETAIL) begin
			detail_clr = PWDATA_IN[DETAIL_W-1:0];
		end
		next_detail = (detail_fault_word & ~detail_clr) | detail_set;
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			detail_fault_word <= '0;
		end else begin
			detail_fault_word <= next_detail;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign apb_setup   = PSEL_IN && !PENABLE_IN;
	assign apb_write   = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign addr_hit    = (PADDR_IN == ADDR_CTRL) || (PADDR_IN == ADDR_EPR) ||
		(PADDR_IN == ADDR_STATUS) || (PADDR_IN == ADDR_DETAIL);
	// Zero wait states keep the answer in the first access cycle
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_hit;

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			ctrl_scripted <= 1'b0;
			ctrl_config   <= 1'b0;
			ctrl_pattern  <= PATTERN_RST;
		end else if (apb_write && PADDR_IN == ADDR_CTRL) begin
			ctrl_scripted <= PWDATA_IN[CTRL_SCRIPTED_BIT];
			ctrl_config   <= PWDATA_IN[CTRL_CONFIG_BIT];
			ctrl_pattern  <= PWDATA_IN[CTRL_PATTERN_LSB +: 4];
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			epr_ms <= EPR_W'(EPR_RST);
		end else if (apb_write && PADDR_IN == ADDR_EPR) begin
			epr_ms <= PWDATA_IN[EPR_W-1:0];
		end
	end

	always_comb begin
		next_rdata = '0;
		unique case (PADDR_IN)
			ADDR_CTRL: begin
				next_rdata[CTRL_SCRIPTED_BIT]       = ctrl_scripted;
				next_rdata[CTRL_CONFIG_BIT]         = ctrl_config;
				next_rdata[CTRL_PATTERN_LSB +: 4]   = ctrl_pattern;
			end
			ADDR_EPR: begin
				next_rdata[EPR_W-1:0] = epr_ms;
			end
			ADDR_STATUS: begin
				next_rdata[3:0]  = next_disp;
				next_rdata[7:4]  = serious_code;
				next_rdata[11:8] = warn_code;
				next_rdata[12]   = serious_latched;
				next_rdata[13]   = warn_active;
				next_rdata[14]   = EMCY_VALID_OUT;
			end
			ADDR_DETAIL: begin
				next_rdata[DETAIL_W-1:0] = detail_fault_word;
			end
			default: begin
				next_rdata = '0;
			end
		endcase
	end

	// Read data is captured in the setup cycle and stands through access
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			PRDATA_OUT <= '0;
		end else if (apb_setup) begin
			PRDATA_OUT <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_red_tracks_err: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		1'b1 |=> STATE_RED_OUT == $past(err_any))
		else $error("red indicator does not follow error state");

	a_emcy_on_raise: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		raise_ok |=> EMCY_VALID_OUT && EMCY_CODE_OUT == $past(ERR_CODE_IN))
		else $error("raised error not offered as emergency");

	a_emcy_stable: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		EMCY_VALID_OUT && !EMCY_READY_IN && !emcy_event |=> EMCY_VALID_OUT && $stable(EMCY_CODE_OUT))
		else $error("emergency dropped before it was taken");

	a_serious_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		serious_latched |=> serious_latched && $stable(serious_code))
		else $error("serious error left the latch");

	a_warn_held: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		raise_warn |=> warn_active [*8])
		else $error("warning not held after raise");

	a_config_pattern: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		ctrl_config |=> ERR_NUM_OUT == $past(ctrl_pattern))
		else $error("config mode leaked an error number");

	a_reserved_drop: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		ERR_RAISE_IN && ERR_CODE_IN == CODE_RESERVED6 && !fb_active |=> $stable(warn_code))
		else $error("reserved number was accepted");

	a_fb_code10: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		fb_active |=> warn_active && warn_code == CODE_FB_GENERAL)
		else $error("fieldbus fault not shown as 10");

	a_detail_set: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		detail_set != '0 |=> (detail_fault_word & $past(detail_set)) == $past(detail_set))
		else $error("detail fault lost against clear");

	a_serious_first: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		serious_latched && !ctrl_config |=> ERR_NUM_OUT == $past(serious_code))
		else $error("warning shown over serious error");

endmodule
`default_nettype wire

// File: bench/gei_emcy_sink.sv
// Emergency consumer standing in for the fieldbus master
`timescale 1ns/10ps
`default_nettype none
module gei_emcy_sink (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Emergency channel
	input  wire logic       valid_in,
	input  wire logic [3:0] code_in,
	output logic            ready_out,
	// Pacing and record
	input  wire logic [3:0] stall_in,
	output logic [3:0]      last_code_out,
	output int              taken_out
);
	logic [3:0] wait_cnt;

	// Ready is a one-cycle grant after stall_in waiting cycles, so both fast and slow takes occur
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ready_out <= 1'b0;
			wait_cnt <= 4'h0;
			last_code_out <= 4'h0;
			taken_out <= 0;
		end else begin
			ready_out <= 1'b0;
			if (valid_in && ready_out) begin
				last_code_out <= code_in;
				taken_out <= taken_out + 1;
			end else if (valid_in) begin
				if (wait_cnt >= stall_in) begin
					ready_out <= 1'b1;
					wait_cnt <= 4'h0;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: bench/gei_tb.sv
// Self-checking bench for the gateway error indicator
`timescale 1ns/10ps
`default_nettype none
module testbench import gei_pkg::*;;
	typedef struct {logic [3:0] code; logic [3:0] num; logic emcy;} gei_row_t;
	gei_row_t rows[11] = '{'{4'h7, 4'h7, 1'b1}, '{4'h8, 4'h8, 1'b1}, '{4'h9, 4'h9, 1'b1},
		'{4'ha, 4'ha, 1'b1}, '{4'hb, 4'hb, 1'b1}, '{4'hc, 4'hc, 1'b1}, '{4'hd, 4'hd, 1'b1},
		'{4'he, 4'he, 1'b1}, '{4'hf, 4'hf, 1'b1}, '{4'h6, 4'hf, 1'b0}, '{4'h0, 4'hf, 1'b0}};
	logic                clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata, q;
	logic                err_raise, expl_traffic, state_red, emcy_valid, emcy_ready, e;
	logic [3:0]          err_code, err_num, emcy_code, stall, last_code;
	logic [DETAIL_W-1:0] detail_fault;
	int                  taken, seen_taken, fail_count, checks, cyc, t0, n;

	// ----------------------------------------------------------------
	// Design and partner
	// ----------------------------------------------------------------
	// Short warning hold keeps the run brief; every hold-timing expectation derives from 50
	gei_error_indicator #(.WARN_HOLD_CYCLES(50)) dut_u (.CLK_SYS_IN(clk_sys),
		.RESET_N_IN(reset_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .ERR_RAISE_IN(err_raise), .ERR_CODE_IN(err_code),
		.DETAIL_FAULT_IN(detail_fault), .EXPL_TRAFFIC_IN(expl_traffic),
		.STATE_RED_OUT(state_red), .ERR_NUM_OUT(err_num), .EMCY_VALID_OUT(emcy_valid),
		.EMCY_CODE_OUT(emcy_code), .EMCY_READY_IN(emcy_ready));
	gei_emcy_sink sink_u (.clk_in(clk_sys), .rst_n_in(reset_n), .valid_in(emcy_valid),
		.code_in(emcy_code), .ready_out(emcy_ready), .stall_in(stall),
		.last_code_out(last_code), .taken_out(taken));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic hang();
		fail_count++;
		print_verdict();
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) hang();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Later reads then see the state settled after the access edge
		#1;
	endtask
	// Display settles one edge after the raise is taken
	task automatic raise(input logic [3:0] c, input logic [3:0] s);
		@(posedge clk_sys);
		err_raise <= 1'b1;
		err_code <= c;
		stall <= s;
		@(posedge clk_sys);
		err_raise <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic check_emcy(input logic [3:0] c);
		int k;
		k = 0;
		while (taken == seen_taken && k < 30) begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 30) hang();
		#1;
		chk({28'h0, last_code}, {28'h0, c});
		seen_taken = taken;
	endtask
	task automatic do_reset();
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		seen_taken = 0;
		chk({state_red, err_num, emcy_valid, pready}, 6'h01);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, err_raise, err_code} = '0;
		{detail_fault, expl_traffic, stall, fail_count, checks, seen_taken} = '0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			raise(rows[i].code, 4'(i % 4));
			chk({state_red, err_num}, {1'b1, rows[i].num});
			if (rows[i].emcy) check_emcy(rows[i].code);
			else chk(32'(taken), 32'(seen_taken));
		end
		// Newer warning restarts the hold; the older one alone would have expired
		do_reset();
		raise(4'h7, 4'h0);
		repeat (30) @(posedge clk_sys);
		raise(4'h8, 4'h0);
		repeat (40) @(posedge clk_sys);
		#1;
		chk({state_red, err_num}, 5'h18);
		n = 0;
		while (state_red !== 1'b0 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 20) hang();
		chk({state_red, err_num}, 5'h00);
		for (int c = 1; c <= 5; c++) begin
			do_reset();
			raise(4'(c), 4'h2);
			chk({state_red, err_num}, {1'b1, 4'(c)});
			check_emcy(4'(c));
		end
		raise(4'h9, 4'h0);
		check_emcy(4'h9);
		raise(4'h2, 4'h0);
		check_emcy(4'h2);
		repeat (80) @(posedge clk_sys);
		#1;
		chk({state_red, err_num}, 5'h15);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({22'h0, q[13:12], q[7:0]}, {22'h0, 2'b01, 8'h55});
		// Pattern differs from the latched number so a leak would show
		apb(1'b1, ADDR_CTRL, 32'h0000_00a2);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({state_red, err_num}, 5'h1a);
		apb(1'b1, ADDR_CTRL, 32'h0000_0000);
		do_reset();
		// Scripted variant: reserved 12 refused, 14 shown, detail faults force 10
		apb(1'b1, ADDR_CTRL, 32'h0000_0001);
		raise(4'hc, 4'h0);
		chk({27'h0, state_red, err_num}, 32'h0);
		chk(32'(taken), 32'(seen_taken));
		raise(4'he, 4'h1);
		chk({state_red, err_num}, 5'h1e);
		check_emcy(4'he);
		for (int i = 0; i < DETAIL_W; i++) begin
			if (i == DET_EXPL_TIMEOUT) continue;
			@(posedge clk_sys);
			detail_fault <= DETAIL_W'(1) << i;
			@(posedge clk_sys);
			detail_fault <= '0;
			apb(1'b0, ADDR_DETAIL, 32'h0);
			chk(q, 32'h1 << i);
			chk({28'h0, err_num}, 32'ha);
			if (i == 0) check_emcy(4'ha);
			apb(1'b1, ADDR_DETAIL, 32'h1 << i);
		end
		apb(1'b0, ADDR_DETAIL, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		// Watchdog: one 1 ms interval, so timeout after four of them
		apb(1'b1, ADDR_EPR, 32'h1);
		@(posedge clk_sys);
		expl_traffic <= 1'b1;
		@(posedge clk_sys);
		expl_traffic <= 1'b0;
		t0 = cyc;
		q = '0;
		while (q[DET_EXPL_TIMEOUT] !== 1'b1 && cyc - t0 < 50000) apb(1'b0, ADDR_DETAIL, 32'h0);
		n = EXPL_TIMEOUT_MULT * CYC_PER_MS;
		chk(32'(cyc - t0 >= n && cyc - t0 < n + 20), 32'h1);
		chk(q, 32'h40);
		print_verdict();
	end
endmodule
`default_nettype wire
